/* src/tlic_pkg.sv */
// constants, addresses and poll order for the two level interrupt controller
package tlic_pkg;
  localparam int unsigned NSRC = 15;
  localparam int unsigned NEXT_P1 = 5;

  // special function register addresses
  localparam logic [7:0] ADR_ENABLE_FIRST   = 8'ha8;
  localparam logic [7:0] ADR_ENABLE_SECOND  = 8'he8;
  localparam logic [7:0] ADR_PRIORITY_FIRST = 8'hb8;
  localparam logic [7:0] ADR_PRIORITY_SECOND = 8'hf8;
  localparam logic [7:0] ADR_REQUEST_FLAG   = 8'hc0;
  localparam logic [7:0] ADR_POLARITY       = 8'he9;
  localparam logic [7:0] ADR_CONTROL        = 8'hc1;
  localparam logic [7:0] ADR_WAKEUP_DISABLE = 8'hb9;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int unsigned GLOBAL_EN_BIT = 7;
  localparam int unsigned FS_FLAG_BIT = 0;
  localparam logic [7:0] PRIO_FIRST_MASK = 8'h7f;

  // request flag register bit positions
  localparam int unsigned FLAG_TIME_BIT = 5;
  localparam int unsigned FLAG_DSP_BIT = 6;
  localparam int unsigned FLAG_RTC_BIT = 7;

  // source numbers
  localparam logic [3:0] SRC_EXT0  = 4'h0;
  localparam logic [3:0] SRC_T0    = 4'h1;
  localparam logic [3:0] SRC_EXT1  = 4'h2;
  localparam logic [3:0] SRC_T1    = 4'h3;
  localparam logic [3:0] SRC_MODEM = 4'h4;
  localparam logic [3:0] SRC_TIME  = 4'h5;
  localparam logic [3:0] SRC_FS    = 4'h6;
  localparam logic [3:0] SRC_EXT2  = 4'h7;
  localparam logic [3:0] SRC_I2C   = 4'hc;
  localparam logic [3:0] SRC_DSP   = 4'hd;
  localparam logic [3:0] SRC_RTC   = 4'he;

  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_LAST = 16'h0073;
  localparam logic [2:0]  VEC_LOW_BITS = 3'h3;

  // source number by rank, rank 1 first
  localparam logic [3:0] POLL_ORDER [NSRC] = '{
    4'h0, 4'h5, 4'ha, 4'h1, 4'h6, 4'hb, 4'h2, 4'h7,
    4'hc, 4'h3, 4'h8, 4'hd, 4'h4, 4'h9, 4'he};
endpackage

/* src/tlic_sync.sv */
// three stage pin synchroniser, output moves when stages two and three agree
module tlic_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level_q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per bit filter: a one cycle glitch past stage two is not taken
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      level_q <= INIT;
    end else begin
      level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
    end
  end
endmodule

/* src/tlic_poll.sv */
// fixed rank poller: picks the first ranked source among requests
module tlic_poll (
  input  wire logic [tlic_pkg::NSRC-1:0] req,
  output logic                           valid,
  output logic [3:0]                     idx
);
  always_comb begin
    idx = '0;
    // walk from the last rank down so the first rank wins
    for (int r = tlic_pkg::NSRC - 1; r >= 0; r--) begin
      if (req[tlic_pkg::POLL_ORDER[r]]) begin
        idx = tlic_pkg::POLL_ORDER[r];
      end
    end
    valid = |req;
  end
endmodule

/* src/tlic_top.sv */
// two level interrupt controller: flags, enables, priorities and vectoring
// Behaviour
// R1: fifteen sources, each set to low or high priority.
// R2: taken source n vectors to 0003 plus eight times n, up to 0073.
// R3: sources seven to eleven come from port-1 bits 0 to 4 only.
// R4: sources zero and two come from the two active-low port-3 pins.
// R5: polarity register selects active level of each port-1 source.
// R6: global enable clear blocks every source.
// R7: per source enable bits, 0-6 first register, 7-14 second.
// R8: detected requests stay latched until serviced, then are taken.
// R9: software clears a latched flag; it may set again at once.
// R10: flags run on the always-on clock, set by pins and events.
// R11: hardware clears only the timer and pin-zero/one flags on service.
// R12: priority bit one means high priority, zero means low.
// R13: any pending high request goes before any low request.
// R14: within a level, poll by fixed rank one to fifteen.
// R15: first priority register at B8, reset 00, bit 7 absent.
// R16: second priority register at F8, reset 00, sources 7 to 14.
// R17: modem source raised by receive or transmit complete.
// R18: spare bits reset 0 and are read-write; absent bits are not.
// R19: polarity bit one makes a port-1 source active high.
// R20: global enable is bit 7 of first enable register, reset 00.
// R21: high preempts low; nothing preempts equal or higher level.
module tlic_top (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  input  wire logic        ext_pin_zero_n,
  input  wire logic        ext_pin_one_n,
  input  wire logic [4:0]  p1_irq_pin,
  input  wire logic        timer_zero_irq,
  input  wire logic        timer_one_irq,
  output logic             timer_zero_ack,
  output logic             timer_one_ack,
  input  wire logic        receive_done,
  input  wire logic        transmit_done,
  input  wire logic        i2c_irq,
  input  wire logic        time_event,
  input  wire logic        dsp_event,
  input  wire logic        frame_sync_event,
  input  wire logic        rtc_event,
  output logic             irq_req,
  output logic      [15:0] irq_vector,
  output logic             irq_level,
  input  wire logic        irq_ack,
  input  wire logic        irq_return,
  output logic      [7:0]  wakeup_disable
);
  localparam int unsigned N = tlic_pkg::NSRC;

  logic [7:0]   enable_reg_first_q;
  logic [7:0]   enable_reg_second_q;
  logic [7:0]   priority_reg_first_q;
  logic [7:0]   priority_reg_second_q;
  logic [7:0]   request_flag_reg_q;
  logic [7:0]   polarity_reg_q;
  logic [7:0]   control_reg_q;
  logic [7:0]   wakeup_disable_reg_q;
  logic [1:0]   ext_flag_q;
  logic [1:0]   ext_prev_q;
  logic [1:0]   ext_lvl;
  logic [4:0]   p1_lvl;
  logic [4:0]   p1_act;
  logic [1:0]   ext_fall;
  logic [7:0]   flag_set;
  logic [N-1:0] src_flag;
  logic [N-1:0] prio_vec;
  logic [N-1:0] pending;
  logic [N-1:0] hi_req;
  logic [N-1:0] lo_req;
  logic         hi_v;
  logic         lo_v;
  logic [3:0]   hi_idx;
  logic [3:0]   lo_idx;
  logic         take_hi;
  logic         take_lo;
  logic [3:0]   sel_idx;
  logic [3:0]   idx_q;
  logic         active_hi_q;
  logic         active_lo_q;
  logic         wr_hit;
  logic         taken;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == tlic_pkg::ADR_ENABLE_FIRST)
             || (a == tlic_pkg::ADR_ENABLE_SECOND)
             || (a == tlic_pkg::ADR_PRIORITY_FIRST)
             || (a == tlic_pkg::ADR_PRIORITY_SECOND)
             || (a == tlic_pkg::ADR_REQUEST_FLAG)
             || (a == tlic_pkg::ADR_POLARITY)
             || (a == tlic_pkg::ADR_CONTROL)
             || (a == tlic_pkg::ADR_WAKEUP_DISABLE);
  endfunction

  function automatic logic wr_to(input logic [7:0] a);
    wr_to = sfr_wr && (sfr_addr == a);
  endfunction

  // pins are asynchronous; idle high for the active-low pair
  tlic_sync #(
    .W    (2),
    .INIT (2'h3)
  ) u_sync_ext (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pin     ({ext_pin_one_n, ext_pin_zero_n}),
    .level_q (ext_lvl)
  ); // [R4]

  // port-1 pins idle high out of reset; a low start would read as active
  tlic_sync #(
    .W    (5),
    .INIT (5'h1f)
  ) u_sync_p1 (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pin     (p1_irq_pin),
    .level_q (p1_lvl)
  ); // [R3]

  // active when the pin matches its polarity bit
  assign p1_act = ~(p1_lvl ^ polarity_reg_q[4:0]); // [R5] [R19]
  assign ext_fall = ext_prev_q & ~ext_lvl; // [R4]

  assign flag_set = {rtc_event, dsp_event, time_event, p1_act}; // [R10]
  assign taken = irq_req && irq_ack;

  // ---- software registers ----
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      enable_reg_first_q  <= tlic_pkg::REG_RESET; // [R20]
      enable_reg_second_q <= tlic_pkg::REG_RESET;
    end else begin
      if (wr_to(tlic_pkg::ADR_ENABLE_FIRST)) begin
        enable_reg_first_q <= sfr_wdata;
      end
      if (wr_to(tlic_pkg::ADR_ENABLE_SECOND)) begin
        enable_reg_second_q <= sfr_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      priority_reg_first_q  <= tlic_pkg::REG_RESET; // [R15]
      priority_reg_second_q <= tlic_pkg::REG_RESET; // [R16]
    end else begin
      if (wr_to(tlic_pkg::ADR_PRIORITY_FIRST)) begin
        // bit 7 has no storage
        priority_reg_first_q <= sfr_wdata
                              & tlic_pkg::PRIO_FIRST_MASK; // [R15]
      end
      if (wr_to(tlic_pkg::ADR_PRIORITY_SECOND)) begin
        priority_reg_second_q <= sfr_wdata; // [R16]
      end
    end
  end

  // spare bits of polarity and control are plain storage
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      polarity_reg_q       <= tlic_pkg::REG_RESET; // [R18]
      wakeup_disable_reg_q <= tlic_pkg::REG_RESET;
    end else begin
      if (wr_to(tlic_pkg::ADR_POLARITY)) begin
        polarity_reg_q <= sfr_wdata;
      end
      if (wr_to(tlic_pkg::ADR_WAKEUP_DISABLE)) begin
        wakeup_disable_reg_q <= sfr_wdata;
      end
    end
  end

  // ---- request flags: hardware set wins over a software clear ----
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      request_flag_reg_q <= tlic_pkg::REG_RESET;
    end else if (wr_to(tlic_pkg::ADR_REQUEST_FLAG)) begin
      request_flag_reg_q <= sfr_wdata | flag_set; // [R9] [R10]
    end else begin
      request_flag_reg_q <= request_flag_reg_q | flag_set; // [R8]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      control_reg_q <= tlic_pkg::REG_RESET; // [R18]
    end else if (wr_to(tlic_pkg::ADR_CONTROL)) begin
      control_reg_q <= sfr_wdata;
      control_reg_q[tlic_pkg::FS_FLAG_BIT] <=
        sfr_wdata[tlic_pkg::FS_FLAG_BIT] | frame_sync_event; // [R10]
    end else if (frame_sync_event) begin
      control_reg_q[tlic_pkg::FS_FLAG_BIT] <= 1'b1; // [R8]
    end
  end

  // pin zero/one flags: falling edge sets, vectoring clears
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ext_prev_q <= 2'h3;
      ext_flag_q <= 2'h0;
    end else begin
      ext_prev_q <= ext_lvl;
      for (int i = 0; i < 2; i++) begin
        if (ext_fall[i]) begin
          ext_flag_q[i] <= 1'b1; // [R4]
        end else if (taken && idx_q == (i == 0 ? tlic_pkg::SRC_EXT0
                                            : tlic_pkg::SRC_EXT1)) begin
          ext_flag_q[i] <= 1'b0; // [R11]
        end
      end
    end
  end

  // timer flags live in the timer block; a pulse tells it to clear
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      timer_zero_ack <= 1'b0;
      timer_one_ack  <= 1'b0;
    end else begin
      timer_zero_ack <= taken && idx_q == tlic_pkg::SRC_T0; // [R11]
      timer_one_ack  <= taken && idx_q == tlic_pkg::SRC_T1; // [R11]
    end
  end

  // ---- source vector in source-number order ----
  always_comb begin
    src_flag = '0;
    src_flag[tlic_pkg::SRC_EXT0]  = ext_flag_q[0];
    src_flag[tlic_pkg::SRC_T0]    = timer_zero_irq;
    src_flag[tlic_pkg::SRC_EXT1]  = ext_flag_q[1];
    src_flag[tlic_pkg::SRC_T1]    = timer_one_irq;
    src_flag[tlic_pkg::SRC_MODEM] = receive_done | transmit_done; // [R17]
    src_flag[tlic_pkg::SRC_TIME]  =
      request_flag_reg_q[tlic_pkg::FLAG_TIME_BIT];
    src_flag[tlic_pkg::SRC_FS]    = control_reg_q[tlic_pkg::FS_FLAG_BIT];
    for (int i = 0; i < tlic_pkg::NEXT_P1; i++) begin
      src_flag[tlic_pkg::SRC_EXT2 + i] = request_flag_reg_q[i]; // [R3]
    end
    src_flag[tlic_pkg::SRC_I2C]   = i2c_irq;
    src_flag[tlic_pkg::SRC_DSP]   =
      request_flag_reg_q[tlic_pkg::FLAG_DSP_BIT];
    src_flag[tlic_pkg::SRC_RTC]   =
      request_flag_reg_q[tlic_pkg::FLAG_RTC_BIT]; // [R1]
  end

  assign prio_vec = {priority_reg_second_q,
                     priority_reg_first_q[6:0]}; // [R12]
  assign pending = src_flag
                 & {enable_reg_second_q, enable_reg_first_q[6:0]} // [R7]
                 & {N{enable_reg_first_q[tlic_pkg::GLOBAL_EN_BIT]}}; // [R6]
  assign hi_req = pending & prio_vec; // [R12]
  assign lo_req = pending & ~prio_vec;

  tlic_poll u_poll_hi (
    .req   (hi_req),
    .valid (hi_v),
    .idx   (hi_idx)
  ); // [R14]

  tlic_poll u_poll_lo (
    .req   (lo_req),
    .valid (lo_v),
    .idx   (lo_idx)
  ); // [R14]

  // high may interrupt low; low waits for every routine to return
  assign take_hi = hi_v && !active_hi_q; // [R13] [R21]
  assign take_lo = lo_v && !hi_v && !active_hi_q && !active_lo_q; // [R21]
  assign sel_idx = take_hi ? hi_idx : lo_idx; // [R13]

  // request is one cycle behind the flags; a flag cleared in that gap
  // can still be vectored, as on a polled core
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq_req    <= 1'b0;
      irq_level  <= 1'b0;
      idx_q      <= 4'h0;
      irq_vector <= tlic_pkg::VEC_BASE;
    end else begin
      irq_req    <= (take_hi || take_lo) && !taken;
      irq_level  <= take_hi;
      idx_q      <= sel_idx;
      irq_vector <= tlic_pkg::VEC_BASE
                  + {9'h000, sel_idx, 3'h0}; // [R2]
    end
  end

  // in-service levels; a return closes the highest open level
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      active_hi_q <= 1'b0;
      active_lo_q <= 1'b0;
    end else if (taken) begin
      if (irq_level) begin
        active_hi_q <= 1'b1; // [R21]
      end else begin
        active_lo_q <= 1'b1; // [R21]
      end
    end else if (irq_return) begin
      if (active_hi_q) begin
        active_hi_q <= 1'b0;
      end else begin
        active_lo_q <= 1'b0; // [R8]
      end
    end
  end

  // ---- read port: data one cycle after the read strobe ----
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end else begin
      sfr_hit <= sfr_rd && is_mapped(sfr_addr);
      if (sfr_rd) begin
        unique case (sfr_addr)
          tlic_pkg::ADR_ENABLE_FIRST:    sfr_rdata <= enable_reg_first_q;
          tlic_pkg::ADR_ENABLE_SECOND:   sfr_rdata <= enable_reg_second_q;
          tlic_pkg::ADR_PRIORITY_FIRST:  sfr_rdata <= priority_reg_first_q;
          tlic_pkg::ADR_PRIORITY_SECOND: sfr_rdata <= priority_reg_second_q;
          tlic_pkg::ADR_REQUEST_FLAG:    sfr_rdata <= request_flag_reg_q;
          tlic_pkg::ADR_POLARITY:        sfr_rdata <= polarity_reg_q;
          tlic_pkg::ADR_CONTROL:         sfr_rdata <= control_reg_q;
          tlic_pkg::ADR_WAKEUP_DISABLE:  sfr_rdata <= wakeup_disable_reg_q;
          default:                       sfr_rdata <= 8'h00;
        endcase
      end
    end
  end

  assign wakeup_disable = wakeup_disable_reg_q;
  assign wr_hit = wr_to(tlic_pkg::ADR_REQUEST_FLAG);

  // ---- checks ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_taken;
    irq_req && irq_ack;
  endsequence

  sequence s_no_flag_wr;
    !wr_hit;
  endsequence

  property p_vec_map;
    irq_req |-> irq_vector[2:0] == tlic_pkg::VEC_LOW_BITS
             && irq_vector <= tlic_pkg::VEC_LAST;
  endproperty
  a_vec_map: assert property (p_vec_map) // [R2]
    else $error("vector off the table");

  property p_global_block;
    !enable_reg_first_q[tlic_pkg::GLOBAL_EN_BIT] |=> !irq_req;
  endproperty
  a_global_block: assert property (p_global_block) // [R6]
    else $error("request with global enable clear");

  property p_enable_gate;
    irq_req |-> $past(pending) != '0;
  endproperty
  a_enable_gate: assert property (p_enable_gate) // [R7]
    else $error("request without enabled pending source");

  property p_hi_first;
    irq_req && !irq_level |-> $past(hi_req) == '0;
  endproperty
  a_hi_first: assert property (p_hi_first) // [R13]
    else $error("low vectored while high pending");

  property p_no_preempt;
    active_hi_q |-> !irq_req;
  endproperty
  a_no_preempt: assert property (p_no_preempt) // [R21]
    else $error("request during high routine");

  property p_ack_drops;
    s_taken |=> !irq_req;
  endproperty
  a_ack_drops: assert property (p_ack_drops) // [R21]
    else $error("request held after ack");

  property p_flag_sticky;
    s_no_flag_wr |=> (request_flag_reg_q & $past(request_flag_reg_q))
                     == $past(request_flag_reg_q);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // [R8]
    else $error("flag lost without software write");

  property p_timer_clear;
    s_taken ##0 idx_q == tlic_pkg::SRC_T0 |=> timer_zero_ack;
  endproperty
  a_timer_clear: assert property (p_timer_clear) // [R11]
    else $error("timer zero not cleared on service");

  property p_pol_set;
    p1_act[0] |=> request_flag_reg_q[0];
  endproperty
  a_pol_set: assert property (p_pol_set) // [R19]
    else $error("active port-1 pin did not set flag");

  property p_rtc_set;
    rtc_event |=> request_flag_reg_q[tlic_pkg::FLAG_RTC_BIT];
  endproperty
  a_rtc_set: assert property (p_rtc_set) // [R10]
    else $error("rtc event not latched");

  property p_absent_bit;
    sfr_rd && sfr_addr == tlic_pkg::ADR_PRIORITY_FIRST |=> !sfr_rdata[7];
  endproperty
  a_absent_bit: assert property (p_absent_bit) // [R15]
    else $error("absent priority bit reads one");
endmodule

/* bench/tlic_core_model.sv */
// core model: takes vectors after a set latency, returns on request
module tlic_core_model (
  input  wire logic        ref_clk,
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  input  wire logic        irq_level,
  input  wire logic [3:0]  lat,
  input  wire logic [31:0] ret_cnt,
  output logic             irq_ack,
  output logic             irq_return,
  output logic      [16:0] taken,
  output logic      [31:0] n_taken
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] ret_done;
  logic [16:0] cap;
  logic [3:0]  w;
  initial begin
    irq_ack = 1'b0;
    irq_return = 1'b0;
    taken = '0;
    n_taken = '0;
    ret_done = '0;
    cap = '0;
    w = '0;
    forever begin
      @(posedge ref_clk);
      #1;
      // ack and return never share a cycle, each is one pulse
      if (irq_ack) begin
        irq_ack = 1'b0;
        taken = cap;
        n_taken = n_taken + 1;
      end else if (irq_return) begin
        irq_return = 1'b0;
      end else if (ret_cnt != ret_done) begin
        irq_return = 1'b1;
        ret_done = ret_done + 1;
      end else if (!irq_req) begin
        w = '0;
      end else if (w < lat) begin
        w = w + 1;
      end else begin
        // vector stands until the ack edge, so capture it now
        irq_ack = 1'b1;
        cap = {irq_level, irq_vector};
        w = '0;
      end
    end
  end
endmodule

/* bench/tlic_top_bench.sv */
// self-checking bench for the two level interrupt controller
module tlic_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, rstn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0] sfr_addr = '0, sfr_wdata = '0, sfr_rdata, wakeup_disable;
  logic sfr_hit, ext_pin_zero_n = 1'b1, ext_pin_one_n = 1'b1;
  logic [4:0] p1_irq_pin = 5'h1f;
  logic timer_zero_irq = 0, timer_one_irq = 0, timer_zero_ack, timer_one_ack;
  logic receive_done = 0, transmit_done = 0, i2c_irq = 0, time_event = 0;
  logic dsp_event = 0, frame_sync_event = 0, rtc_event = 0;
  logic irq_req, irq_level, irq_ack, irq_return, polb = 1'b0, r_mod, rd_p;
  logic [15:0] irq_vector;
  logic [16:0] taken, tq [$];
  logic [31:0] n_taken, seen = '0, ret_cnt = '0;
  logic [3:0] lat = '0;
  logic [8:0] rq [$], fl;
  logic [7:0] v, w, p0, p1;
  int miscompares = 0, total_checks = 0, cyc = 0, acks = 0, ord [$];
  logic [7:0] ra [6] = '{8'ha8, 8'he8, 8'hb8, 8'hf8, 8'hb9, 8'hc1};
  logic [7:0] wm [6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hfe};
  logic [7:0] rm [6] = '{8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff};
  always #12.5 ref_clk = ~ref_clk;
  tlic_top tlic_top_i (.*);
  tlic_core_model tlic_core_model_i (.*);
  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    acks += int'(timer_zero_ack) + int'(timer_one_ack);
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
    if (n_taken != seen) begin
      seen = n_taken;
      chk(taken, tq.pop_front());
    end
    if (rd_p) begin
      rd_p = 1'b0;
      chk({8'h00, sfr_hit, sfr_rdata}, {8'h00, rq.pop_front()});
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge ref_clk);
    #2 sfr_wr = 1'b0;
    // idle edge so a following strobe is not raised in the same step
    cyc_wait(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    rq.push_back(e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge ref_clk);
    #2 sfr_rd = 1'b0;
    rd_p = 1'b1;
    cyc_wait(1);
  endtask
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // pins need about five edges through the synchroniser before clearing
  task automatic settle();
    cyc_wait(8);
    wr(8'hc0, 8'h00);
    wr(8'hc1, 8'h00);
  endtask
  task automatic wait_take(input logic [31:0] t);
    repeat (300) if (n_taken < t) @(posedge ref_clk);
    #2 chk(n_taken, t);
  endtask
  task automatic src(input int s, input logic v);
    case (s)
      0: ext_pin_zero_n = ~v;
      1: timer_zero_irq = v;
      2: ext_pin_one_n = ~v;
      3: timer_one_irq = v;
      4: if (r_mod) transmit_done = v; else receive_done = v;
      12: i2c_irq = v;
      7, 8, 9, 10, 11: p1_irq_pin[s-7] = ~(v ^ polb);
      default: if (v) begin
        {time_event, frame_sync_event, dsp_event, rtc_event} =
          {s == 5, s == 6, s == 13, s == 14};
        @(posedge ref_clk);
        #2 {time_event, frame_sync_event, dsp_event, rtc_event} = 4'h0;
        cyc_wait(1);
      end
    endcase
  endtask
  function automatic logic [8:0] fbit(input int s);
    case (s)
      5: return 9'h020;
      6: return 9'h100;
      13: return 9'h040;
      14: return 9'h080;
      7, 8, 9, 10, 11: return 9'h001 << (s - 7);
      default: return 9'h000;
    endcase
  endfunction
  initial begin
    rd_p = 1'b0;
    r_mod = 1'b0;
    fl = '0;
    void'($urandom(32'hac1e57bf));
    cyc_wait(20);
    rstn = 1'b1;
    cyc_wait(4);
    foreach (ra[i]) rd(ra[i], 9'h100);
    rd(8'hc0, 9'h100);
    rd(8'he9, 9'h100);
    rd(8'h00, 9'h000);
    // read-back, absent bit 7 of first priority register reads zero
    foreach (ra[i]) begin
      v = 8'($urandom);
      w = v & wm[i];
      wr(ra[i], w);
      rd(ra[i], {1'b1, w & rm[i]});
      if (ra[i] == 8'hb9) chk(wakeup_disable, w);
      wr(ra[i], 8'h00);
    end
    wr(8'he9, 8'he0);
    rd(8'he9, 9'h1e0);
    // flag sets again while the port-1 source stays active
    wr(8'he9, 8'h01);
    settle();
    rd(8'hc0, 9'h101);
    p1_irq_pin[0] = 1'b0;
    settle();
    rd(8'hc0, 9'h100);
    wr(8'he9, 8'h00);
    p1_irq_pin[0] = 1'b1;
    settle();
    // all sources pending, then global enable: high by rank, low by rank
    for (int r = 0; r < 2; r++) begin
      r_mod = r[0];
      polb = ~r[0];
      p1_irq_pin = {5{~polb}};
      wr(8'he9, {3'h0, {5{polb}}});
      settle();
      lat = 4'($urandom_range(6));
      p0 = 8'($urandom) & 8'h7f;
      p1 = 8'($urandom);
      wr(8'hb8, p0);
      wr(8'hf8, p1);
      wr(8'he8, 8'hff);
      wr(8'ha8, 8'h7f);
      for (int s = 0; s < 15; s++) src(s, 1'b1);
      fl = 9'h1ff;
      cyc_wait(20);
      chk(irq_req, 1'b0);
      for (int h = 1; h >= 0; h--)
        for (int k = 0; k < tlic_pkg::NSRC; k++) begin
          int s;
          s = int'(tlic_pkg::POLL_ORDER[k]);
          if ((s < 7 ? p0[s] : p1[s-7]) == h[0]) begin
            tq.push_back({h[0], 16'h0003 + 16'(8 * s)});
            ord.push_back(s);
          end
        end
      wr(8'ha8, 8'hff);
      for (int k = 0; k < 15; k++) begin
        wait_take(seen + 1);
        src(ord[0], 1'b0);
        fl = fl & ~fbit(ord.pop_front());
        cyc_wait(8);
        wr(8'hc0, fl[7:0]);
        wr(8'hc1, {7'h0, fl[8]});
        ret_cnt++;
      end
      cyc_wait(20);
      wr(8'ha8, 8'h00);
    end
    // a high request preempts an open low routine, then waits on returns
    wr(8'hb8, 8'h00);
    wr(8'hf8, 8'h20);
    wr(8'he8, 8'h20);
    wr(8'ha8, 8'ha2);
    tq.push_back({1'b0, 16'h000b});
    src(1, 1'b1);
    wait_take(seen + 1);
    tq.push_back({1'b1, 16'h0063});
    src(12, 1'b1);
    wait_take(seen + 1);
    src(1, 1'b0);
    src(12, 1'b0);
    src(5, 1'b1);
    cyc_wait(20);
    chk(n_taken, seen);
    ret_cnt++;
    cyc_wait(20);
    chk(n_taken, seen);
    tq.push_back({1'b0, 16'h002b});
    ret_cnt++;
    wait_take(seen + 1);
    wr(8'hc0, 8'h00);
    ret_cnt++;
    cyc_wait(20);
    chk(acks, 5);
    chk(tq.size(), 0);
    end_of_test();
  end
endmodule
